// ---- hdl/technology_pid_controller.sv ----
// technology pid controller with scaled setpoints, ramp, smoothing and limits
`timescale 1ns/1ps
module technology_pid_controller
  import tech_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // register port
  input  wire logic        [5:0]  reg_addr,
  input  wire logic        [15:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic             [15:0] reg_rdata,
  // process signals
  input  wire logic        [3:0]  controller_enable_source,
  input  wire logic signed [15:0] setpoint_one_source,
  input  wire logic signed [15:0] setpoint_two_source,
  input  wire logic signed [15:0] actual_value_source,
  input  wire logic signed [15:0] precontrol_a,
  input  wire logic signed [15:0] precontrol_b,
  // controller result
  output logic signed      [15:0] controller_output_signal,
  output logic                    output_strobe,
  output logic                    controller_running
);
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007fff)
      return FULL_POS;
    else if (v < -40'sh0000008000)
      return FULL_NEG;
    else
      return v[15:0];
  endfunction
  function automatic logic signed [15:0] mul_frac(input logic signed [15:0] a,
                                                  input logic signed [15:0] b,
                                                  input int                 frac);
    logic signed [39:0] p;
    p = 40'(a * b);
    return sat16(p >>> frac);
  endfunction
  // first-order lag as y += (x - y) / 2^n; n = 0 passes straight through
  function automatic logic signed [15:0] pt1(input logic signed [15:0] y,
                                             input logic signed [15:0] x,
                                             input logic        [3:0]  n);
    logic signed [39:0] d;
    d = 40'(x) - 40'(y);
    return sat16(40'(y) + (d >>> n));
  endfunction
  // move cur toward tgt by at most step lsb; step held signed so a fall compares right
  function automatic logic signed [15:0] approach(input logic signed [15:0] cur,
                                                  input logic signed [15:0] tgt,
                                                  input logic        [15:0] step);
    logic signed [39:0] d;
    logic signed [39:0] s;
    d = 40'(tgt) - 40'(cur);
    s = 40'(step);
    if (d > s)
      return sat16(40'(cur) + s);
    else if (-d > s)
      return sat16(40'(cur) - s);
    else
      return tgt;
  endfunction
  // configuration registers
  logic        [15:0] control;
  logic signed [15:0] setpoint_one_scale;
  logic signed [15:0] setpoint_two_scale;
  logic        [15:0] ramp_up_time;
  logic        [15:0] ramp_down_time;
  logic        [3:0]  setpoint_smoothing_time;
  logic        [3:0]  actual_smoothing_time;
  logic        [3:0]  derivative_time;
  logic signed [15:0] proportional_gain;
  logic        [3:0]  integral_action_time;
  logic signed [15:0] output_upper_limit;
  logic signed [15:0] output_lower_limit;
  logic signed [15:0] output_scale;
  // datapath state
  logic        [7:0]  tick_cnt;
  logic               tick;
  logic        [15:0] up_cnt;
  logic        [15:0] down_cnt;
  logic        [15:0] up_credit;
  logic        [15:0] down_credit;
  logic signed [15:0] ramp_out;
  logic signed [15:0] sp_filt;
  logic signed [15:0] act_filt;
  logic signed [15:0] d_prev;
  logic signed [39:0] int_acc;
  logic signed [15:0] eff_upper;
  logic signed [15:0] eff_lower;
  logic               at_upper;
  logic               at_lower;
  logic        [7:0]  next_tick_cnt;
  logic               next_tick;
  logic        [15:0] next_up_cnt;
  logic        [15:0] next_down_cnt;
  logic        [15:0] next_up_credit;
  logic        [15:0] next_down_credit;
  logic signed [15:0] next_ramp_out;
  logic signed [15:0] next_sp_filt;
  logic signed [15:0] next_act_filt;
  logic signed [15:0] next_d_prev;
  logic signed [39:0] next_int_acc;
  logic signed [15:0] next_eff_upper;
  logic signed [15:0] next_eff_lower;
  logic               next_at_upper;
  logic               next_at_lower;
  logic signed [15:0] next_output;
  logic               next_running;
  logic        [15:0] next_rdata;
  // combinational terms
  logic               enable;
  logic        [15:0] up_step;
  logic        [15:0] down_step;
  logic signed [15:0] sp_sum;
  logic signed [15:0] dev;
  logic signed [15:0] d_src;
  logic signed [15:0] p_term;
  logic signed [15:0] i_term;
  logic signed [15:0] d_term;
  logic signed [15:0] pre;
  logic signed [15:0] scaled;
  logic signed [15:0] limited;
  always_comb
  begin
    // enable from a selectable binary source; codes above always-on mean off
    enable = (control[CTL_EN_SEL_LSB +: 3] == EN_SEL_ALWAYS)
           || (!control[CTL_EN_SEL_LSB + 2]
               && controller_enable_source[control[CTL_EN_SEL_LSB +: 2]]);
    // sample period divider; the filters, limits, controller and output below act only on tick
    next_tick     = (tick_cnt == 8'(SAMPLE_CYCLES - 1));
    next_tick_cnt = next_tick ? 8'h00 : tick_cnt + 8'h01;
    // ramp credits accrue one lsb per ramp_*_time clocks, are spent once per sample
    up_step   = (ramp_up_time == 16'h0000) ? STEP_UNLIMITED : up_credit;
    down_step = (ramp_down_time == 16'h0000) ? STEP_UNLIMITED : down_credit;
    next_up_cnt      = (up_cnt >= ramp_up_time - 16'h0001) ? 16'h0000 : up_cnt + 16'h0001;
    next_down_cnt    = (down_cnt >= ramp_down_time - 16'h0001) ? 16'h0000 : down_cnt + 16'h0001;
    next_up_credit   = tick ? 16'h0000 : up_credit;
    next_down_credit = tick ? 16'h0000 : down_credit;
    if (!tick && up_cnt == 16'h0000 && up_credit != STEP_UNLIMITED)
      next_up_credit = up_credit + 16'h0001;
    if (!tick && down_cnt == 16'h0000 && down_credit != STEP_UNLIMITED)
      next_down_credit = down_credit + 16'h0001;
    sp_sum = sat16(40'(mul_frac(setpoint_one_source, setpoint_one_scale, SCALE_FRAC))
                 + 40'(mul_frac(setpoint_two_source, setpoint_two_scale, SCALE_FRAC)));
    dev   = sat16(40'(sp_filt) - 40'(act_filt));
    // d on the actual value enters with negative sign
    d_src = control[CTL_DTYPE_BIT] ? dev : sat16(-40'(act_filt));
    p_term = mul_frac(proportional_gain, dev, GAIN_FRAC);
    i_term = (integral_action_time == 4'h0) ? 16'sh0000
           : sat16(int_acc >>> integral_action_time);
    d_term = (derivative_time == 4'h0) ? 16'sh0000
           : sat16(40'(mul_frac(proportional_gain, sat16(40'(d_src) - 40'(d_prev)),
                                GAIN_FRAC)) <<< (derivative_time - 4'h1));
    unique case (control[CTL_PRE_LSB +: 2])
      PRE_A:   pre = precontrol_a;
      PRE_B:   pre = precontrol_b;
      default: pre = 16'sh0000;
    endcase
    scaled = mul_frac(sat16(40'(p_term) + 40'(i_term) + 40'(d_term) + 40'(pre)),
                      output_scale, SCALE_FRAC);
    if (control[CTL_INVERT_BIT])
      scaled = sat16(-40'(scaled));
    limited = (scaled > eff_upper) ? eff_upper
            : ((scaled < eff_lower) ? eff_lower : scaled);
    next_ramp_out  = ramp_out;
    next_sp_filt   = sp_filt;
    next_act_filt  = act_filt;
    next_d_prev    = d_prev;
    next_int_acc   = int_acc;
    next_eff_upper = eff_upper;
    next_eff_lower = eff_lower;
    next_at_upper  = at_upper;
    next_at_lower  = at_lower;
    next_output    = controller_output_signal;
    next_running   = controller_running;
    if (tick)
    begin
      next_running  = enable;
      next_act_filt = pt1(act_filt, actual_value_source, actual_smoothing_time);
      next_d_prev   = d_src;
      // limits travel at the ramp rates when switched in or out
      next_eff_upper = approach(eff_upper,
                                control[CTL_LIMIT_BIT] ? output_upper_limit : FULL_POS,
                                (output_upper_limit < eff_upper) ? down_step : up_step);
      next_eff_lower = approach(eff_lower,
                                control[CTL_LIMIT_BIT] ? output_lower_limit : FULL_NEG,
                                (output_lower_limit > eff_lower) ? up_step : down_step);
      if (enable)
      begin
        next_ramp_out = approach(ramp_out, sp_sum,
                                 (sp_sum > ramp_out) ? up_step : down_step);
        next_sp_filt  = pt1(sp_filt, ramp_out, setpoint_smoothing_time);
        // integration frozen while the output sits on a limit in that direction
        if (integral_action_time == 4'h0)
          next_int_acc = 40'sh0;
        else if (!((at_upper && p_term > 0) || (at_lower && p_term < 0)))
          next_int_acc = int_acc + 40'(p_term);
        next_output   = limited;
        next_at_upper = (scaled >= eff_upper);
        next_at_lower = (scaled <= eff_lower);
      end
      else
      begin
        next_ramp_out = 16'sh0000;
        next_sp_filt  = pt1(sp_filt, 16'sh0000, setpoint_smoothing_time);
        next_int_acc  = 40'sh0;
        next_output   = 16'sh0000;
        next_at_upper = 1'b0;
        next_at_lower = 1'b0;
      end
    end
    unique case (reg_addr)
      OFS_CONTROL:      next_rdata = control;
      OFS_SP_ONE_SCALE: next_rdata = setpoint_one_scale;
      OFS_SP_TWO_SCALE: next_rdata = setpoint_two_scale;
      OFS_RAMP_UP:      next_rdata = ramp_up_time;
      OFS_RAMP_DOWN:    next_rdata = ramp_down_time;
      OFS_SP_SMOOTH:    next_rdata = {12'h000, setpoint_smoothing_time};
      OFS_ACT_SMOOTH:   next_rdata = {12'h000, actual_smoothing_time};
      OFS_DERIV_TIME:   next_rdata = {12'h000, derivative_time};
      OFS_PROP_GAIN:    next_rdata = proportional_gain;
      OFS_INT_TIME:     next_rdata = {12'h000, integral_action_time};
      OFS_UPPER_LIMIT:  next_rdata = output_upper_limit;
      OFS_LOWER_LIMIT:  next_rdata = output_lower_limit;
      OFS_OUT_SCALE:    next_rdata = output_scale;
      OFS_STATUS:       next_rdata = {13'h0000, at_lower, at_upper, controller_running};
      OFS_OUTPUT:       next_rdata = controller_output_signal;
      OFS_RAMP_OUT:     next_rdata = ramp_out;
      default:          next_rdata = 16'h0000;
    endcase
    if (!reg_rd)
      next_rdata = 16'h0000;
  end
  // register writes
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      control                 <= RST_CONTROL;
      setpoint_one_scale      <= RST_SCALE;
      setpoint_two_scale      <= RST_SCALE;
      ramp_up_time            <= RST_RAMP;
      ramp_down_time          <= RST_RAMP;
      setpoint_smoothing_time <= RST_SHIFT;
      actual_smoothing_time   <= RST_SHIFT;
      derivative_time         <= RST_SHIFT;
      proportional_gain       <= RST_GAIN;
      integral_action_time    <= RST_SHIFT;
      output_upper_limit      <= RST_UPPER;
      output_lower_limit      <= RST_LOWER;
      output_scale            <= RST_SCALE;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_CONTROL:      control                 <= reg_wdata;
        OFS_SP_ONE_SCALE: setpoint_one_scale      <= reg_wdata;
        OFS_SP_TWO_SCALE: setpoint_two_scale      <= reg_wdata;
        OFS_RAMP_UP:      ramp_up_time            <= reg_wdata;
        OFS_RAMP_DOWN:    ramp_down_time          <= reg_wdata;
        OFS_SP_SMOOTH:    setpoint_smoothing_time <= reg_wdata[3:0];
        OFS_ACT_SMOOTH:   actual_smoothing_time   <= reg_wdata[3:0];
        OFS_DERIV_TIME:   derivative_time         <= reg_wdata[3:0];
        OFS_PROP_GAIN:    proportional_gain       <= reg_wdata;
        OFS_INT_TIME:     integral_action_time    <= reg_wdata[3:0];
        OFS_UPPER_LIMIT:  output_upper_limit      <= reg_wdata;
        OFS_LOWER_LIMIT:  output_lower_limit      <= reg_wdata;
        OFS_OUT_SCALE:    output_scale            <= reg_wdata;
        default:          ;
      endcase
    end
  end
  // datapath state and outputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt                 <= 8'h00;
      tick                     <= 1'b0;
      up_cnt                   <= 16'h0000;
      down_cnt                 <= 16'h0000;
      up_credit                <= 16'h0000;
      down_credit              <= 16'h0000;
      ramp_out                 <= 16'sh0000;
      sp_filt                  <= 16'sh0000;
      act_filt                 <= 16'sh0000;
      d_prev                   <= 16'sh0000;
      int_acc                  <= 40'sh0;
      eff_upper                <= FULL_POS;
      eff_lower                <= FULL_NEG;
      at_upper                 <= 1'b0;
      at_lower                 <= 1'b0;
      controller_output_signal <= 16'sh0000;
      output_strobe            <= 1'b0;
      controller_running       <= 1'b0;
      reg_rdata                <= 16'h0000;
    end
    else
    begin
      tick_cnt                 <= next_tick_cnt;
      tick                     <= next_tick;
      up_cnt                   <= next_up_cnt;
      down_cnt                 <= next_down_cnt;
      up_credit                <= next_up_credit;
      down_credit              <= next_down_credit;
      ramp_out                 <= next_ramp_out;
      sp_filt                  <= next_sp_filt;
      act_filt                 <= next_act_filt;
      d_prev                   <= next_d_prev;
      int_acc                  <= next_int_acc;
      eff_upper                <= next_eff_upper;
      eff_lower                <= next_eff_lower;
      at_upper                 <= next_at_upper;
      at_lower                 <= next_at_lower;
      controller_output_signal <= next_output;
      output_strobe            <= tick;
      controller_running       <= next_running;
      reg_rdata                <= next_rdata;
    end
  end
endmodule // technology_pid_controller

// ---- hdl/tech_ctrl_pkg.sv ----
// constants, register map and reset values of the technology controller
package tech_ctrl_pkg;
  // clock and controller sample period
  localparam int CLK_PERIOD_NS    = 4;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_CYCLES    = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ramp credit: one lsb of travel every ramp_*_time clock cycles
  localparam logic [15:0] STEP_UNLIMITED = 16'hffff;

  // register offsets on the plain port
  localparam logic [5:0] OFS_CONTROL      = 6'h00;
  localparam logic [5:0] OFS_SP_ONE_SCALE = 6'h04;
  localparam logic [5:0] OFS_SP_TWO_SCALE = 6'h08;
  localparam logic [5:0] OFS_RAMP_UP      = 6'h0c;
  localparam logic [5:0] OFS_RAMP_DOWN    = 6'h10;
  localparam logic [5:0] OFS_SP_SMOOTH    = 6'h14;
  localparam logic [5:0] OFS_ACT_SMOOTH   = 6'h18;
  localparam logic [5:0] OFS_DERIV_TIME   = 6'h1c;
  localparam logic [5:0] OFS_PROP_GAIN    = 6'h20;
  localparam logic [5:0] OFS_INT_TIME     = 6'h24;
  localparam logic [5:0] OFS_UPPER_LIMIT  = 6'h28;
  localparam logic [5:0] OFS_LOWER_LIMIT  = 6'h2c;
  localparam logic [5:0] OFS_OUT_SCALE    = 6'h30;
  localparam logic [5:0] OFS_STATUS       = 6'h34;
  localparam logic [5:0] OFS_OUTPUT       = 6'h38;
  localparam logic [5:0] OFS_RAMP_OUT     = 6'h3c;

  // control register fields
  localparam int CTL_EN_SEL_LSB = 0;
  localparam int CTL_DTYPE_BIT  = 3;
  localparam int CTL_INVERT_BIT = 4;
  localparam int CTL_LIMIT_BIT  = 5;
  localparam int CTL_PRE_LSB    = 6;
  localparam logic [2:0] EN_SEL_ALWAYS = 3'h4;
  localparam logic [1:0] PRE_NONE      = 2'h0;
  localparam logic [1:0] PRE_A         = 2'h1;
  localparam logic [1:0] PRE_B         = 2'h2;

  // fixed point: scales q4.12, gain q8.8
  localparam int SCALE_FRAC = 12;
  localparam int GAIN_FRAC  = 8;

  // reset values
  localparam logic [15:0] RST_CONTROL   = 16'h0000;
  localparam logic [15:0] RST_SCALE     = 16'h1000;
  localparam logic [15:0] RST_RAMP      = 16'h0000;
  localparam logic [3:0]  RST_SHIFT     = 4'h0;
  localparam logic [15:0] RST_GAIN      = 16'h0100;
  localparam logic [15:0] RST_UPPER     = 16'h7fff;
  localparam logic [15:0] RST_LOWER     = 16'h8000;
  localparam logic [15:0] FULL_POS      = 16'h7fff;
  localparam logic [15:0] FULL_NEG      = 16'h8000;
endpackage

// ---- dv/technology_pid_controller_assertions.sv ----
// port-level checker for the technology pid controller
`timescale 1ns/1ps
module technology_pid_controller_checker
  import tech_ctrl_pkg::*;
(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // register port
  input wire logic        [5:0]  reg_addr,
  input wire logic               reg_rd,
  input wire logic        [15:0] reg_rdata,
  // controller result
  input wire logic signed [15:0] controller_output_signal,
  input wire logic               output_strobe,
  input wire logic               controller_running
);
  logic [15:0] gap;
  logic        seen;

  // cycles since the last strobe; the first strobe has no reference
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap  <= 16'h0000;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= output_strobe ? 16'h0000 : gap + 16'h0001;
      seen <= seen | output_strobe;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_strobe_pulse;
    output_strobe |=> !output_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one cycle");
  property p_strobe_period;
    output_strobe && seen |-> gap == SAMPLE_CYCLES - 1;
  endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("sample period wrong");
  property p_out_hold;
    !output_strobe |-> $stable(controller_output_signal);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved between samples");
  property p_off_zero;
    output_strobe && !controller_running |-> controller_output_signal == 16'sh0000;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("output not zero while off");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_rd_output;
    reg_rd && reg_addr == OFS_OUTPUT |=> reg_rdata == $past(controller_output_signal);
  endproperty
  a_rd_output: assert property (p_rd_output) else $error("output register mismatch");
  property p_rd_status;
    reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[0] == $past(controller_running);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("running bit mismatch");
  property p_unmapped;
    reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_run: cover property (output_strobe && controller_running);
  c_read_out: cover property (reg_rd && reg_addr == OFS_OUTPUT);
  c_negative: cover property (output_strobe && controller_output_signal < 0);
endmodule // technology_pid_controller_checker

// ---- dv/process_partner.sv ----
// level sensor feeding the actual value and speed setpoint path taking the output
`timescale 1ns/1ps
module process_partner
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // level commanded by the bench
  input  wire logic signed [15:0] level,
  // controller result
  input  wire logic signed [15:0] controller_output_signal,
  input  wire logic               output_strobe,
  // towards controller and drive
  output logic signed      [15:0] actual_value_source,
  output logic signed      [15:0] speed_setpoint
);
  // sensor adds one cycle of conversion delay
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      actual_value_source <= 16'sh0000;
      speed_setpoint      <= 16'sh0000;
    end
    else
    begin
      actual_value_source <= level;
      if (output_strobe)
        speed_setpoint <= controller_output_signal;
    end
  end
endmodule // process_partner

// ---- dv/test_technology_pid_controller.sv ----
// self-checking bench of the technology pid controller
`timescale 1ns/1ps
module test_technology_pid_controller
  import tech_ctrl_pkg::*;
();
  logic               clk_sys, rst_b, reg_wr, reg_rd, output_strobe, controller_running;
  logic        [5:0]  reg_addr;
  logic        [15:0] reg_wdata, reg_rdata, rd_v;
  logic        [3:0]  controller_enable_source;
  logic signed [15:0] setpoint_one_source, setpoint_two_source, actual_value_source;
  logic signed [15:0] precontrol_a, precontrol_b, controller_output_signal, level;
  logic signed [15:0] speed_setpoint;
  int n_errors, n_tests, seed, s1, s2, osc, hi, lo, a, b, c, pa, pb, pv, ok, on;
  bit inv;
  logic [5:0]  ra [10] = '{OFS_CONTROL, OFS_SP_ONE_SCALE, OFS_SP_TWO_SCALE, OFS_RAMP_UP,
    OFS_PROP_GAIN, OFS_UPPER_LIMIT, OFS_LOWER_LIMIT, OFS_OUT_SCALE, OFS_INT_TIME, 6'h02};
  logic [15:0] rv [10] = '{RST_CONTROL, RST_SCALE, RST_SCALE, RST_RAMP, RST_GAIN,
    RST_UPPER, RST_LOWER, RST_SCALE, 16'h0000, 16'h0000};

  technology_pid_controller DUT (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .controller_enable_source, .setpoint_one_source, .setpoint_two_source,
    .actual_value_source, .precontrol_a, .precontrol_b, .controller_output_signal,
    .output_strobe, .controller_running);
  process_partner u_partner (.clk_sys, .rst_b, .level, .controller_output_signal,
    .output_strobe, .actual_value_source, .speed_setpoint);

  function automatic int sat(input int v);
    return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
  endfunction
  // p-only steady state with unit gain
  function automatic int expect_out(input int sp1, sp2, act, pre);
    int v;
    v = sat(sat(((sp1 * s1) >>> 12) + ((sp2 * s2) >>> 12)) - act);
    v = sat((sat(v + pre) * osc) >>> 12);
    v = inv ? -v : v;
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ad);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  task automatic drive(input int sp1, sp2, act, xa, xb);
    @(posedge clk_sys);
    setpoint_one_source <= 16'(sp1);
    setpoint_two_source <= 16'(sp2);
    level               <= 16'(act);
    precontrol_a        <= 16'(xa);
    precontrol_b        <= 16'(xb);
  endtask
  // waits for n output strobes, bounded per sample
  task automatic tick(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(negedge clk_sys);
        k++;
      end
      while (output_strobe !== 1'b1 && k < 300);
    end
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // about 150 samples, some 38000 cycles, expected
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end

  initial
  begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, controller_enable_source} = '0;
    {setpoint_one_source, setpoint_two_source, level, precontrol_a, precontrol_b} = '0;
    seed = 32'h735f;
    {s1, s2, osc, hi, lo, inv} = {32'd4096, 32'd4096, 32'd4096, 32'd32767, -32'sd32768, 1'b0};
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(6'h02, 16'h5a5a);
    foreach (ra[i])
    begin
      rd(ra[i]);
      check(rd_v, rv[i]);
    end
    $display("test reset values done");
    drive(500, 0, 0, 0, 0);
    for (int sel = 0; sel < 6; sel++)
    begin
      on = (sel < 4) ? (1 << sel) : 15;
      wr(OFS_CONTROL, 16'(sel));
      @(posedge clk_sys);
      controller_enable_source <= 4'(on);
      tick(3);
      check(16'(controller_running), 16'(sel != 5));
      @(posedge clk_sys);
      controller_enable_source <= 4'(~on);
      tick(3);
      check(16'(controller_running), 16'(sel == 4));
      rd(OFS_RAMP_OUT);
      if (sel != 4)
        check(rd_v, 16'h0000);
      rd(OFS_STATUS);
      check(16'(rd_v[0]), 16'(sel == 4));
    end
    $display("test enable done");
    for (int i = 0; i < 6; i++)
    begin
      {a, b, c} = {$random(seed) % 1024, $random(seed) % 1024, $random(seed) % 1024};
      {pa, pb} = {$random(seed) % 512, $random(seed) % 512};
      s1 = {$random(seed)} % 8192;
      s2 = (i == 0) ? 0 : {$random(seed)} % 8192;
      pv = (i % 3 == 1) ? pa : ((i % 3 == 2) ? pb : 0);
      wr(OFS_SP_ONE_SCALE, 16'(s1));
      wr(OFS_SP_TWO_SCALE, 16'(s2));
      wr(OFS_CONTROL, {8'h00, 2'(i % 3), 3'h0, EN_SEL_ALWAYS});
      drive(a, b, c, pa, pb);
      tick(6);
      check(controller_output_signal, 16'(expect_out(a, b, c, pv)));
      rd(OFS_OUTPUT);
      check(rd_v, 16'(expect_out(a, b, c, pv)));
      check(speed_setpoint, 16'(expect_out(a, b, c, pv)));
    end
    {s1, s2} = {32'd4096, 32'd4096};
    wr(OFS_SP_ONE_SCALE, 16'h1000);
    wr(OFS_SP_TWO_SCALE, 16'h1000);
    $display("test scaling and pre-control done");
    {inv, osc} = {1'b1, 32'd2048};
    wr(OFS_OUT_SCALE, 16'h0800);
    wr(OFS_CONTROL, 16'h0014);
    drive(300, 100, 50, 0, 0);
    tick(6);
    check(controller_output_signal, 16'(expect_out(300, 100, 50, 0)));
    {inv, osc, hi, lo} = {1'b0, 32'd4096, 32'd300, -32'sd300};
    wr(OFS_OUT_SCALE, 16'h1000);
    wr(OFS_UPPER_LIMIT, 16'h012c);
    wr(OFS_LOWER_LIMIT, 16'hfed4);
    wr(OFS_CONTROL, 16'h0024);
    drive(900, 0, 0, 0, 0);
    tick(6);
    check(controller_output_signal, 16'(expect_out(900, 0, 0, 0)));
    rd(OFS_STATUS);
    check(rd_v, 16'h0003);
    drive(-900, 0, 0, 0, 0);
    tick(6);
    check(controller_output_signal, 16'(expect_out(-900, 0, 0, 0)));
    {hi, lo} = {32'd32767, -32'sd32768};
    wr(OFS_CONTROL, 16'h0004);
    tick(6);
    check(controller_output_signal, 16'(expect_out(-900, 0, 0, 0)));
    $display("test invert and limits done");
    drive(200, 0, 0, 0, 0);
    wr(OFS_DERIV_TIME, 16'h0001);
    tick(6);
    drive(600, 0, 0, 0, 0);
    ok = 1;
    repeat (5)
    begin
      tick(1);
      ok &= (controller_output_signal == 200 || controller_output_signal == 600);
    end
    check(16'(ok), 16'h0001);
    wr(OFS_CONTROL, 16'h000c);
    tick(6);
    drive(200, 0, 0, 0, 0);
    ok = 0;
    repeat (5)
    begin
      tick(1);
      ok |= (controller_output_signal != 200 && controller_output_signal != 600);
    end
    check(16'(ok), 16'h0001);
    wr(OFS_DERIV_TIME, 16'h0000);
    wr(OFS_CONTROL, 16'h0004);
    $display("test derivative placement done");
    drive(0, 0, 0, 0, 0);
    tick(6);
    wr(OFS_RAMP_UP, 16'd50);
    drive(1000, 0, 0, 0, 0);
    tick(3);
    check(16'(controller_output_signal >= 0 && controller_output_signal <= 50), 16'h0001);
    wr(OFS_RAMP_UP, 16'h0000);
    tick(6);
    wr(OFS_RAMP_DOWN, 16'd50);
    drive(0, 0, 0, 0, 0);
    tick(3);
    check(16'(controller_output_signal >= 950), 16'h0001);
    wr(OFS_RAMP_DOWN, 16'h0000);
    $display("test ramp done");
    drive(100, 0, 0, 0, 0);
    tick(6);
    wr(OFS_INT_TIME, 16'h0001);
    tick(4);
    check(16'(controller_output_signal > 100), 16'h0001);
    wr(OFS_INT_TIME, 16'h0000);
    tick(4);
    check(controller_output_signal, 16'(expect_out(100, 0, 0, 0)));
    $display("test integral done");
    summarize();
  end
endmodule // test_technology_pid_controller

bind technology_pid_controller technology_pid_controller_checker u_chk (.clk_sys, .rst_b,
  .reg_addr, .reg_rd, .reg_rdata, .controller_output_signal, .output_strobe,
  .controller_running);
